// ---- verilog/acc_consts.vh ----
// Constants for the analog comparator control block: register map, field
// positions, reset values and event mode codes.
// Assumes inclusion by bare name from the design files.
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

`define ACC_ADDR_W         4
`define ACC_DATA_W         8

`define ACC_ADDR_SC        4'h0
`define ACC_ADDR_IRQ_STAT  4'h1
`define ACC_ADDR_IRQ_CLR   4'h2
`define ACC_ADDR_IRQ_EN    4'h3

`define ACC_BIT_EN         7
`define ACC_BIT_REF        6
`define ACC_BIT_FLAG       5
`define ACC_BIT_IE         4
`define ACC_BIT_OUT        3
`define ACC_BIT_OPE        2
`define ACC_MODE_MSB       1
`define ACC_MODE_LSB       0

`define ACC_MODE_FALL_A    2'h0
`define ACC_MODE_RISE      2'h1
`define ACC_MODE_FALL_B    2'h2
`define ACC_MODE_BOTH      2'h3

`define ACC_SC_RESET       8'h00
`define ACC_MODE_RESET     2'h0

`define ACC_IRQ_W          3
`define ACC_EV_CMP         0
`define ACC_EV_RISE        1
`define ACC_EV_FALL        2
`define ACC_IRQ_RESET      3'h0

`define ACC_SETTLE_CYC     2'h3

`endif

// ---- verilog/acc_sync.v ----
// Two-stage synchroniser with edge detection for the comparator output.
// Assumes the input is asynchronous; clr primes the history to low.
`timescale 1ns/10ps

module acc_sync (
	input  wire clk,
	input  wire nrst,
	input  wire clk_en,
	input  wire clr,
	input  wire async_in,
	output wire level,
	output wire rise,
	output wire fall
);

	reg s1_ff;
	reg s2_ff;
	reg prev_ff;

	// First stage feeds only the second stage
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_ff   <= 1'b0;
			s2_ff   <= 1'b0;
			prev_ff <= 1'b0;
		end else if (clk_en) begin
			if (clr) begin
				s1_ff   <= 1'b0;
				s2_ff   <= 1'b0;
				prev_ff <= 1'b0;
			end else begin
				s1_ff   <= async_in;
				s2_ff   <= s1_ff;
				prev_ff <= s2_ff;
			end
		end
	end

	assign level = s2_ff;
	assign rise  = s2_ff & ~prev_ff;
	assign fall  = ~s2_ff & prev_ff;

endmodule

// ---- verilog/acc_ctrl.v ----
// Control and status logic around an analog comparator: one status and
// control register, edge event flag, interrupt, capture routing, low power.
// Assumes a single bus clock, a plain strobe register port and an external
// analog core whose output arrives asynchronously.
`timescale 1ns/10ps
`include "acc_consts.vh"

// Functional notes
// - Control bit 7 turns the comparator module on; zero keeps it off.
// - Bit 6 picks external positive pin (0) or internal bandgap (1).
// - Bit 5 flag sets on each compare event chosen by the mode field.
// - Writing one to bit 5 clears the flag; writing zero leaves it.
// - With bit 4 set, interrupt request stands while the flag is set.
// - Bit 3 reads the live comparator level, forced zero while disabled.
// - Bit 2 output-pin enable is reserved here and does nothing.
// - Mode bits 1:0: 00 fall, 01 rise, 10 fall, 11 either edge.
// - Output high when non-inverting input exceeds inverting input, else low.
// - Capture routing sends comparator output to timer one channel 0 capture.
// - While routed, timer one channel 0 pin is unavailable externally.
// - Enabled before wait, it keeps running and its interrupt can wake.
// - Disabled in every stop mode; never a wake-up source from stop.
// - Deepest two stop modes power it down; it wakes in reset state.
// - Lightest stop freezes clocks, keeps registers, detects no events.
// - Light stop left by reset resets it; by interrupt it resumes.
// - In active background debug it keeps operating normally.
module acc_ctrl (
	input  wire                    clk,
	input  wire                    nrst,
	input  wire                    clk_en,
	input  wire [`ACC_ADDR_W-1:0]  addr,
	input  wire [`ACC_DATA_W-1:0]  wdata,
	input  wire                    wr_stb,
	input  wire                    rd_stb,
	output reg  [`ACC_DATA_W-1:0]  rdata,
	output reg                     irq,
	output reg                     wake_req,
	input  wire                    cmp_raw,
	output reg                     cmp_power,
	output reg                     reference_select,
	input  wire                    capture_route_select,
	input  wire                    timer1_channel0_pin_in,
	input  wire                    timer1_channel0_pin_oe_req,
	output reg                     timer1_channel0_pin_oe,
	output reg                     timer1_capture_in,
	input  wire                    wait_mode,
	input  wire                    stop_light,
	input  wire                    stop_deep
);

	localparam [3:0] ST_OFF    = 4'b0001;
	localparam [3:0] ST_SETTLE = 4'b0010;
	localparam [3:0] ST_RUN    = 4'b0100;
	localparam [3:0] ST_HOLD   = 4'b1000;

	reg  [3:0]              state_ff;
	reg  [3:0]              nxt_state;
	reg  [1:0]              settle_ff;
	reg  [1:0]              nxt_settle;

	reg                     comparator_enable_ff;
	reg                     reference_select_ff;
	reg                     compare_event_flag_ff;
	reg                     compare_interrupt_enable_ff;
	reg  [1:0]              event_mode_select_ff;
	reg  [`ACC_IRQ_W-1:0]   irq_stat_ff;
	reg  [`ACC_IRQ_W-1:0]   irq_en_ff;

	reg                     nxt_enable;
	reg                     nxt_ref;
	reg                     nxt_flag;
	reg                     nxt_ie;
	reg  [1:0]              nxt_mode;
	reg                     mode_hit;
	reg  [`ACC_IRQ_W-1:0]   nxt_irq_en;
	reg  [`ACC_DATA_W-1:0]  nxt_rdata;
	reg                     nxt_irq;

	wire                    sync_level;
	wire                    sync_rise;
	wire                    sync_fall;
	wire                    sync_clr;
	wire                    running;
	wire                    live_level;
	wire                    cmp_event;
	wire [`ACC_IRQ_W-1:0]   irq_events;
	wire [`ACC_IRQ_W-1:0]   nxt_irq_stat;
	wire                    wr_sc;
	wire                    wr_clr;
	wire                    wr_en;
	wire                    bus_ok;

	// Registers are only reachable while the bus clock runs to the block
	assign bus_ok = ~stop_light & ~stop_deep;
	assign wr_sc  = wr_stb & bus_ok & (addr == `ACC_ADDR_SC);
	assign wr_clr = wr_stb & bus_ok & (addr == `ACC_ADDR_IRQ_CLR);
	assign wr_en  = wr_stb & bus_ok & (addr == `ACC_ADDR_IRQ_EN);

	// History is cleared whenever not sampling so a re-enable or a resume
	// from light stop never sees a stale level as an edge
	assign sync_clr = ~(state_ff[2] | state_ff[1]);
	// Enable gates too, so a disabling write mutes the level at once
	assign running  = state_ff[2] & comparator_enable_ff;

	// Raw level is already high for non-inverting above inverting
	acc_sync u_sync (
		.clk      (clk),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.clr      (sync_clr),
		.async_in (cmp_raw),
		.level    (sync_level),
		.rise     (sync_rise),
		.fall     (sync_fall)
	);

	assign live_level = running & sync_level;

	// Mode decode; both fall codes behave alike
	always @* begin
		mode_hit = 1'b0;
		case (event_mode_select_ff)
			`ACC_MODE_FALL_A: begin
				mode_hit = sync_fall;
			end
			`ACC_MODE_RISE: begin
				mode_hit = sync_rise;
			end
			`ACC_MODE_FALL_B: begin
				mode_hit = sync_fall;
			end
			`ACC_MODE_BOTH: begin
				mode_hit = sync_rise | sync_fall;
			end
			default: begin
				mode_hit = 1'b0;
			end
		endcase
	end

	assign cmp_event = running & mode_hit;

	assign irq_events[`ACC_EV_CMP]  = cmp_event;
	assign irq_events[`ACC_EV_RISE] = running & sync_rise;
	assign irq_events[`ACC_EV_FALL] = running & sync_fall;

	// One sticky status bit per event; the event outranks a same-cycle clear
	genvar gi;
	generate
		for (gi = 0; gi < `ACC_IRQ_W; gi = gi + 1) begin : g_stat
			wire clr_bit;
			wire hold_bit;
			assign clr_bit  = wr_clr & wdata[gi];
			assign hold_bit = irq_stat_ff[gi] & ~clr_bit;
			assign nxt_irq_stat[gi] = irq_events[gi] | hold_bit;
		end
	endgenerate

	// Power sequencing state
	always @* begin
		nxt_state  = state_ff;
		nxt_settle = settle_ff;
		case (state_ff)
			ST_OFF: begin
				if (comparator_enable_ff & ~stop_light) begin
					nxt_state  = ST_SETTLE;
					nxt_settle = `ACC_SETTLE_CYC;
				end
			end
			ST_SETTLE: begin
				// Junk from the unpowered core must leave the edge history
				// first, so entering RUN never looks like an edge
				if (stop_light) begin
					nxt_state = ST_HOLD;
				end else if (~comparator_enable_ff) begin
					nxt_state = ST_OFF;
				end else if (settle_ff == 2'h0) begin
					nxt_state = ST_RUN;
				end else begin
					nxt_settle = settle_ff - 2'h1;
				end
			end
			ST_RUN: begin
				// Wait mode and background debug leave it running
				if (stop_light) begin
					nxt_state = ST_HOLD;
				end else if (~comparator_enable_ff) begin
					nxt_state = ST_OFF;
				end
			end
			ST_HOLD: begin
				if (~stop_light) begin
					// Resume on interrupt exit; re-prime the history first
					if (comparator_enable_ff) begin
						nxt_state  = ST_SETTLE;
						nxt_settle = `ACC_SETTLE_CYC;
					end else begin
						nxt_state = ST_OFF;
					end
				end
			end
			default: begin
				nxt_state  = ST_OFF;
				nxt_settle = 2'h0;
			end
		endcase
	end

	// Register next values
	always @* begin
		nxt_enable   = comparator_enable_ff;
		nxt_ref      = reference_select_ff;
		nxt_ie       = compare_interrupt_enable_ff;
		nxt_mode     = event_mode_select_ff;
		nxt_flag     = compare_event_flag_ff;
		nxt_irq_en   = irq_en_ff;
		if (wr_sc) begin
			nxt_enable = wdata[`ACC_BIT_EN];
			nxt_ref    = wdata[`ACC_BIT_REF];
			nxt_ie     = wdata[`ACC_BIT_IE];
			nxt_mode   = wdata[`ACC_MODE_MSB:`ACC_MODE_LSB];
			// Bit 2 write is dropped: no output pin exists
			if (wdata[`ACC_BIT_FLAG]) begin
				nxt_flag = 1'b0;
			end
		end
		if (wr_en) begin
			nxt_irq_en = wdata[`ACC_IRQ_W-1:0];
		end
		// Set after clear so a same-cycle event survives
		if (cmp_event) begin
			nxt_flag = 1'b1;
		end
	end

	// Read data: valid only in the cycle after the strobe
	always @* begin
		nxt_rdata = {`ACC_DATA_W{1'b0}};
		if (rd_stb & bus_ok) begin
			case (addr)
				`ACC_ADDR_SC: begin
					nxt_rdata[`ACC_BIT_EN]   = comparator_enable_ff;
					nxt_rdata[`ACC_BIT_REF]  = reference_select_ff;
					nxt_rdata[`ACC_BIT_FLAG] = compare_event_flag_ff;
					nxt_rdata[`ACC_BIT_IE]   = compare_interrupt_enable_ff;
					nxt_rdata[`ACC_BIT_OUT]  = live_level;
					nxt_rdata[`ACC_BIT_OPE]  = 1'b0;
					nxt_rdata[`ACC_MODE_MSB:`ACC_MODE_LSB] = event_mode_select_ff;
				end
				`ACC_ADDR_IRQ_STAT: begin
					nxt_rdata[`ACC_IRQ_W-1:0] = irq_stat_ff;
				end
				`ACC_ADDR_IRQ_EN: begin
					nxt_rdata[`ACC_IRQ_W-1:0] = irq_en_ff;
				end
				default: begin
					nxt_rdata = {`ACC_DATA_W{1'b0}};
				end
			endcase
		end
	end

	// Request from the next register values so irq lines up with the flag
	always @* begin
		nxt_irq = 1'b0;
		if (nxt_flag & nxt_ie) begin
			nxt_irq = 1'b1;
		end
		// Status bits share the one request line
		if (|(nxt_irq_stat & nxt_irq_en)) begin
			nxt_irq = 1'b1;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff                    <= ST_OFF;
			settle_ff                   <= 2'h0;
			comparator_enable_ff        <= 1'b0;
			reference_select_ff         <= 1'b0;
			compare_event_flag_ff       <= 1'b0;
			compare_interrupt_enable_ff <= 1'b0;
			event_mode_select_ff        <= `ACC_MODE_RESET;
			irq_stat_ff                 <= `ACC_IRQ_RESET;
			irq_en_ff                   <= `ACC_IRQ_RESET;
			rdata                       <= {`ACC_DATA_W{1'b0}};
			irq                         <= 1'b0;
		end else if (clk_en) begin
			if (stop_deep) begin
				// Powered down: everything returns to reset values
				state_ff                    <= ST_OFF;
				settle_ff                   <= 2'h0;
				comparator_enable_ff        <= 1'b0;
				reference_select_ff         <= 1'b0;
				compare_event_flag_ff       <= 1'b0;
				compare_interrupt_enable_ff <= 1'b0;
				event_mode_select_ff        <= `ACC_MODE_RESET;
				irq_stat_ff                 <= `ACC_IRQ_RESET;
				irq_en_ff                   <= `ACC_IRQ_RESET;
				rdata                       <= {`ACC_DATA_W{1'b0}};
				irq                         <= 1'b0;
			end else begin
				state_ff                    <= nxt_state;
				settle_ff                   <= nxt_settle;
				comparator_enable_ff        <= nxt_enable;
				reference_select_ff         <= nxt_ref;
				compare_event_flag_ff       <= nxt_flag;
				compare_interrupt_enable_ff <= nxt_ie;
				event_mode_select_ff        <= nxt_mode;
				irq_stat_ff                 <= nxt_irq_stat;
				irq_en_ff                   <= nxt_irq_en;
				rdata                       <= nxt_rdata;
				irq                         <= nxt_irq;
			end
		end
	end

	// Outward controls to the analog core and the timer
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmp_power              <= 1'b0;
			reference_select       <= 1'b0;
			wake_req               <= 1'b0;
			timer1_channel0_pin_oe <= 1'b0;
			timer1_capture_in      <= 1'b0;
		end else if (clk_en) begin
			// Analog core is off in any stop, whatever software set
			cmp_power        <= nxt_enable & ~stop_light & ~stop_deep;
			// Powered down core must see the reset reference choice
			reference_select <= nxt_ref & ~stop_deep;
			// Wake only from wait; stop modes never get one
			wake_req         <= nxt_irq & wait_mode & ~stop_light & ~stop_deep;
			// Routed: timer pad is taken off the pin
			timer1_channel0_pin_oe <= timer1_channel0_pin_oe_req & ~capture_route_select;
			if (capture_route_select) begin
				timer1_capture_in <= live_level;
			end else begin
				timer1_capture_in <= timer1_channel0_pin_in;
			end
		end
	end

endmodule

// ---- dv/acc_core_model.sv ----
// Behavioural analog comparator core feeding the control block.
// Assumes the bench sets the pin voltages in millivolts.
`timescale 1ns/10ps

module acc_core_model #(
	parameter int BANDGAP_MV = 1200
) (
	input  wire logic clk,
	input  wire logic cmp_power,
	input  wire logic reference_select,
	input  int        pos_mv,
	input  int        neg_mv,
	output logic      cmp_raw
);
	int noninv_mv;

	initial cmp_raw = 1'b0;
	assign noninv_mv = reference_select ? BANDGAP_MV : pos_mv;
	// Unpowered core output is junk, so toggle rather than hold
	always @(posedge clk) begin
		cmp_raw <= cmp_power ? (noninv_mv > neg_mv) : ~cmp_raw;
	end
endmodule

// ---- dv/acc_ctrl_asserts.sv ----
// Port-level checker for the comparator control block.
// Assumes one clock domain and binding to the block's top.
`timescale 1ns/10ps
`include "acc_consts.vh"

module acc_ctrl_asserts (
	input wire logic                   clk,
	input wire logic                   nrst,
	input wire logic                   clk_en,
	input wire logic [`ACC_ADDR_W-1:0] addr,
	input wire logic [`ACC_DATA_W-1:0] wdata,
	input wire logic                   wr_stb,
	input wire logic                   rd_stb,
	input wire logic [`ACC_DATA_W-1:0] rdata,
	input wire logic                   irq,
	input wire logic                   wake_req,
	input wire logic                   cmp_raw,
	input wire logic                   cmp_power,
	input wire logic                   reference_select,
	input wire logic                   capture_route_select,
	input wire logic                   timer1_channel0_pin_in,
	input wire logic                   timer1_channel0_pin_oe_req,
	input wire logic                   timer1_channel0_pin_oe,
	input wire logic                   timer1_capture_in,
	input wire logic                   wait_mode,
	input wire logic                   stop_light,
	input wire logic                   stop_deep
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_rdata_idle: assert property (clk_en && !rd_stb |=> rdata == 8'h00)
		else $error("read data not zero outside read cycle");
	a_enable_write: assert property (clk_en && wr_stb && addr == `ACC_ADDR_SC && !stop_light && !stop_deep
		|=> cmp_power == $past(wdata[`ACC_BIT_EN])) else $error("core power does not follow enable");
	a_ref_write: assert property (clk_en && wr_stb && addr == `ACC_ADDR_SC && !stop_light && !stop_deep
		|=> reference_select == $past(wdata[`ACC_BIT_REF])) else $error("reference select not updated");
	a_level_off: assert property (clk_en && rd_stb && addr == `ACC_ADDR_SC && !cmp_power
		|=> !rdata[`ACC_BIT_OUT]) else $error("level reads high while off");
	a_reserved_zero: assert property (clk_en && rd_stb && addr == `ACC_ADDR_SC
		|=> !rdata[`ACC_BIT_OPE]) else $error("reserved bit reads high");
	a_pin_blocked: assert property (clk_en && !stop_deep
		|=> timer1_channel0_pin_oe == ($past(timer1_channel0_pin_oe_req) && !$past(capture_route_select)))
		else $error("pin drive wrong for routing");
	a_pin_capture: assert property (clk_en && !stop_deep && !capture_route_select
		|=> timer1_capture_in == $past(timer1_channel0_pin_in)) else $error("capture does not follow pin");
	a_wake_wait: assert property (wake_req |-> irq && $past(wait_mode))
		else $error("wake without interrupt in wait");
	a_stop_quiet: assert property (clk_en && (stop_light || stop_deep) |=> !cmp_power && !wake_req)
		else $error("core powered or waking in stop");
	a_deep_clear: assert property (clk_en && stop_deep |=> !irq && !reference_select && rdata == 8'h00)
		else $error("deep stop left state behind");
endmodule

// ---- dv/test_analog_comparator_control.sv ----
// Register-level test of the comparator control block with a core model.
// Assumes the design and constants header are compiled first.
`timescale 1ns/10ps
`include "acc_consts.vh"

module test_analog_comparator_control;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic       clk_en = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr_stb = 1'b0;
	logic       rd_stb = 1'b0;
	logic       route = 1'b0;
	logic       pin_in = 1'b0;
	logic       oe_req = 1'b0;
	logic       wait_mode = 1'b0;
	logic       stop_light = 1'b0;
	logic       stop_deep = 1'b0;
	wire  [7:0] rdata;
	wire        irq, wake_req, cmp_raw, cmp_power, ref_sel, pin_oe, cap_in;
	int         pos_mv = 100;
	int         neg_mv = 500;
	int         fails = 0;
	int         comparisons = 0;

	always #50 clk = ~clk;

	acc_ctrl u_dut (.clk(clk), .nrst(nrst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .irq(irq), .wake_req(wake_req), .cmp_raw(cmp_raw),
		.cmp_power(cmp_power), .reference_select(ref_sel), .capture_route_select(route),
		.timer1_channel0_pin_in(pin_in), .timer1_channel0_pin_oe_req(oe_req),
		.timer1_channel0_pin_oe(pin_oe), .timer1_capture_in(cap_in), .wait_mode(wait_mode),
		.stop_light(stop_light), .stop_deep(stop_deep));
	acc_core_model u_core (.clk(clk), .cmp_power(cmp_power), .reference_select(ref_sel),
		.pos_mv(pos_mv), .neg_mv(neg_mv), .cmp_raw(cmp_raw));

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a; wdata <= d; wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a; rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 chk("rdata", rdata, e);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		test_done;
	end

	initial begin
		cyc(6);
		@(posedge clk) nrst <= 1'b1;
		rd(`ACC_ADDR_SC, 8'h00);
		rd(4'hf, 8'h00);
		wr(`ACC_ADDR_SC, 8'hc1);
		cyc(5);
		chk("power", cmp_power, 8'h01);
		rd(`ACC_ADDR_SC, 8'hc9);
		wr(`ACC_ADDR_SC, 8'h81);
		cyc(5);
		rd(`ACC_ADDR_SC, 8'h81);
		pos_mv = 900;
		cyc(5);
		rd(`ACC_ADDR_SC, 8'ha9);
		wr(`ACC_ADDR_SC, 8'h81);
		rd(`ACC_ADDR_SC, 8'ha9);
		wr(`ACC_ADDR_SC, 8'ha1);
		rd(`ACC_ADDR_SC, 8'h89);
		for (int i = 0; i < 4; i++) begin
			wr(`ACC_ADDR_SC, {6'h28, i[1:0]});
			pos_mv = 100;
			cyc(5);
			rd(`ACC_ADDR_SC, {2'b10, i != 1, 3'b000, i[1:0]});
			wr(`ACC_ADDR_SC, {6'h28, i[1:0]});
			pos_mv = 900;
			cyc(5);
			rd(`ACC_ADDR_SC, {2'b10, i[0], 3'b010, i[1:0]});
		end
		wr(`ACC_ADDR_SC, 8'hb1);
		@(posedge clk) wait_mode <= 1'b1;
		cyc(2);
		chk("irq", irq, 8'h00);
		pos_mv = 100;
		cyc(5);
		pos_mv = 900;
		cyc(5);
		chk("irq", irq, 8'h01);
		chk("wake", wake_req, 8'h01);
		wr(`ACC_ADDR_SC, 8'h81);
		cyc(2);
		chk("irq", irq, 8'h00);
		rd(4'h1, 8'h07);
		wr(4'h3, 8'h02);
		rd(4'h3, 8'h02);
		cyc(2);
		chk("irq", irq, 8'h01);
		wr(4'h2, 8'h07);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h00);
		cyc(2);
		chk("irq", irq, 8'h00);
		wr(`ACC_ADDR_SC, 8'ha1);
		@(posedge clk) stop_light <= 1'b1;
		pos_mv = 100;
		wr(`ACC_ADDR_SC, 8'h00);
		cyc(5);
		chk("power", cmp_power, 8'h00);
		@(posedge clk) stop_light <= 1'b0;
		cyc(6);
		rd(`ACC_ADDR_SC, 8'h81);
		@(posedge clk) clk_en <= 1'b0;
		wr(`ACC_ADDR_SC, 8'h00);
		@(posedge clk) clk_en <= 1'b1;
		rd(`ACC_ADDR_SC, 8'h81);
		@(posedge clk) begin
			route <= 1'b1; oe_req <= 1'b1; pin_in <= 1'b1;
		end
		cyc(3);
		chk("pin_oe", pin_oe, 8'h00);
		chk("capture", cap_in, 8'h00);
		@(posedge clk) route <= 1'b0;
		cyc(3);
		chk("pin_oe", pin_oe, 8'h01);
		chk("capture", cap_in, 8'h01);
		// Rise reaches the flag on the very edge that samples the clearing write
		pos_mv = 900;
		cyc(2);
		wr(`ACC_ADDR_SC, 8'ha1);
		rd(`ACC_ADDR_SC, 8'ha9);
		@(posedge clk) stop_deep <= 1'b1;
		cyc(2);
		@(posedge clk) stop_deep <= 1'b0;
		rd(`ACC_ADDR_SC, 8'h00);
		test_done;
	end
endmodule

bind acc_ctrl acc_ctrl_asserts u_chk (.clk(clk), .nrst(nrst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .wake_req(wake_req), .cmp_raw(cmp_raw),
	.cmp_power(cmp_power), .reference_select(reference_select), .capture_route_select(capture_route_select),
	.timer1_channel0_pin_in(timer1_channel0_pin_in), .timer1_channel0_pin_oe_req(timer1_channel0_pin_oe_req),
	.timer1_channel0_pin_oe(timer1_channel0_pin_oe), .timer1_capture_in(timer1_capture_in),
	.wait_mode(wait_mode), .stop_light(stop_light), .stop_deep(stop_deep));
